// ===== rtl/sadc_defs.svh
// Constants for the simultaneous ADC acquisition controller.
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH
`define SADC_A_CTRL      8'h00
`define SADC_A_STATUS    8'h04
`define SADC_A_RATE      8'h08
`define SADC_A_POINTS    8'h0C
`define SADC_A_CHCFG     8'h10
`define SADC_A_AVG       8'h14
`define SADC_A_TRIG      8'h18
`define SADC_A_DATA      8'h1C
`define SADC_A_SAMP01    8'h20
`define SADC_A_SAMP23    8'h24
`define SADC_A_CHEN      8'h28
`define SADC_CTL_POLL    0
`define SADC_CTL_SINGLE  1
`define SADC_CTL_CONT    2
`define SADC_CTL_STOP    3
`define SADC_CTL_TRIGSW  4
`define SADC_CLK_HZ      125000000
`define SADC_RATE_RST    32'h0000_03E8
`define SADC_POINTS_RST  32'h0000_01F4
`define SADC_RANGE_RST   2'h0
`define SADC_POL_RST     1'b0
`define SADC_SINGLE_MAX  32'h0080_0000
`define SADC_CONT_MAX    32'h0040_0000
`define SADC_MAXRATE_16  32'h0007_A120
`define SADC_MAXRATE_14  32'h001E_8480
`define SADC_CAL_WORDS   8
`endif

// ===== rtl/sadc_pkg.sv
// Types for the simultaneous ADC acquisition controller.
package sadc_pkg;
  typedef enum logic [2:0] {
    SADC_CAL   = 3'b000,
    SADC_IDLE  = 3'b001,
    SADC_POLL  = 3'b010,
    SADC_ARM   = 3'b011,
    SADC_RUN   = 3'b100
  } sadc_state_e;
  typedef enum logic [1:0] {
    SADC_TRG_NONE = 2'h0,
    SADC_TRG_DIG  = 2'h1,
    SADC_TRG_ANA  = 2'h2,
    SADC_TRG_SW   = 2'h3
  } sadc_trig_e;
endpackage : sadc_pkg

// ===== rtl/sadc_fifo.sv
// Sample FIFO holding 16-bit words for the host.
`timescale 1ns/1ns
module sadc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic             do_wr;
  logic             do_rd;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (level != DEPTH[AW:0]);
  assign out_valid = (level != '0);
  assign out_data  = mem[rptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // Storage has no reset; only the pointers and the level need a defined value.
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wptr] <= in_data;
    end
  end

  // Pointer and level bookkeeping; flush empties the FIFO.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wptr  <= '0;
      rptr  <= '0;
      level <= '0;
    end else if (flush) begin
      wptr  <= '0;
      rptr  <= '0;
      level <= '0;
    end else begin
      if (do_wr) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (do_rd) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      level <= level + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule : sadc_fifo

// ===== rtl/sadc_ctrl.sv
// Acquisition controller for four simultaneously sampled differential inputs.
//
// Contract
// R1: all four channels sampled at one instant
// R2: one conversion per poll command; the code runs avg_n conversions per command and returns their mean
// R3: polling timing only from host command
// R4: sampled acquisition waits for trigger condition
// R5: samples are written into data FIFO
// R6: per-channel range and polarity setting
// R7: reset gives widest range and bipolar
// R8: averaging count returns mean of N
// R9: single-shot stops after configured points
// R10: continuous runs until stop command
// R11: one programmed rate, bounded by variant
// R12: sampling rate resets to 1 kHz
// R13: total samples equal points times channels
// R14: sample points reset to 500
// R15: load calibration constants at power-up first
// R16: host sets analog threshold before start
// R17: 14-bit or 16-bit sample width
// R18: buffer capacity limits total points
// R19: LSB first, low channel first, pad
// R20: reject out-of-range rate or points
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "sadc_defs.svh"
module sadc_ctrl
  import sadc_pkg::*;
#(
  parameter int SAMPLE_BITS = 16,
  parameter int FIFO_DEPTH  = 64
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             adc_convst,
  input  wire logic        adc_done,
  input  wire logic [63:0] adc_data,
  output logic [11:0]      adc_range_pol,
  input  wire logic        ext_dig_trig,
  input  wire logic        ana_trig_hit,
  output logic             cal_rd,
  output logic [2:0]       cal_addr,
  input  wire logic        cal_valid,
  input  wire logic [15:0] cal_word,
  output logic             cal_we,
  output logic [2:0]       cal_dst,
  output logic [15:0]      cal_out,
  output logic             busy
);
  localparam logic [31:0] MAXRATE =
    (SAMPLE_BITS == 14) ? `SADC_MAXRATE_14 : `SADC_MAXRATE_16;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  sadc_state_e      state;
  sadc_trig_e       trig_src;
  logic [31:0]      rate;
  logic [31:0]      points;
  logic [3:0]       chen;
  logic [11:0]      chcfg;
  logic [15:0]      avg_n;
  logic [15:0]      avg_cnt;
  logic [31:0]      acc [4];
  logic [15:0]      result [4];
  logic [31:0]      pace_cnt;
  logic [31:0]      pt_cnt;
  logic             mode_cont;
  logic             conv_pend;
  logic [1:0]       ch_idx;
  logic             push_busy;
  logic [15:0]      hold [4];
  logic             done_flag;
  logic [3:0]       cal_cnt;
  logic             wr_cyc;
  logic             rd_cyc;
  logic             f_in_valid;
  logic             f_in_ready;
  logic [15:0]      f_in_data;
  logic             f_out_valid;
  logic             f_out_ready;
  logic [15:0]      f_out_data;
  logic [LW-1:0]    f_level;
  logic             fifo_flush;
  logic             trig_ok;
  logic [31:0]      cap_max;
  logic [31:0]      next_prdata;
  logic [2:0]       n_en;

  // Count of enabled channels, used to scale buffer capacity.
  function automatic logic [2:0] count_en(input logic [3:0] m);
    count_en = 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
  endfunction : count_en

  // Word aligns a sample: a 14-bit code sits above two unused bits.
  function automatic logic [15:0] align(input logic [15:0] s); // R17
    align = (SAMPLE_BITS == 14) ? {s[13:0], 2'b00} : s;
  endfunction : align

  assign wr_cyc = psel && penable && pwrite;
  assign rd_cyc = psel && penable && !pwrite;
  assign n_en   = count_en(chen);
  assign cap_max = (mode_cont ? `SADC_CONT_MAX : `SADC_SINGLE_MAX) /
                   {29'h0, (n_en == 3'h0) ? 3'h1 : n_en}; // R18

  // Trigger qualification; analog level is compared outside.
  always_comb begin
    case (trig_src)
      SADC_TRG_DIG: trig_ok = ext_dig_trig;
      SADC_TRG_ANA: trig_ok = ana_trig_hit; // R16
      SADC_TRG_SW:  trig_ok = wr_cyc && (paddr == `SADC_A_CTRL) &&
                              pwdata[`SADC_CTL_TRIGSW];
      default:      trig_ok = 1'b1;
    endcase
  end

  // APB slave answers in the access cycle, so every transfer is 2 cycles.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr[1:0] != 2'h0 ||
                 paddr > `SADC_A_CHEN);
    end
  end

  // Configuration registers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rate     <= `SADC_RATE_RST; // R12
      points   <= `SADC_POINTS_RST; // R14
      chcfg    <= {4{`SADC_POL_RST, `SADC_RANGE_RST}}; // R7
      avg_n    <= 16'h0001;
      trig_src <= SADC_TRG_NONE;
      chen     <= 4'hF;
    end else if (wr_cyc && pready && state == SADC_IDLE) begin
      case (paddr)
        `SADC_A_RATE: begin
          if (pwdata != 32'h0 && pwdata <= MAXRATE) begin // R20
            rate <= pwdata; // R11
          end
        end
        `SADC_A_POINTS: begin
          if (pwdata != 32'h0 && pwdata <= cap_max) begin // R20
            points <= pwdata;
          end
        end
        `SADC_A_CHCFG: chcfg <= pwdata[11:0]; // R6
        `SADC_A_AVG:   avg_n <= (pwdata[15:0] == 16'h0) ? 16'h1 :
                                pwdata[15:0];
        `SADC_A_TRIG:  trig_src <= sadc_trig_e'(pwdata[1:0]);
        `SADC_A_CHEN:  chen <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Range/polarity drive the gain stage; reset is widest bipolar.
  // Each channel owns three bits, {polarity, range}, channel 0 lowest.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      adc_range_pol <= {4{`SADC_POL_RST, `SADC_RANGE_RST}}; // R7
    end else begin
      adc_range_pol <= chcfg; // R6
    end
  end

  // Power-up calibration copy from nonvolatile memory.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_cnt  <= 4'h0;
      cal_rd   <= 1'b0;
      cal_addr <= 3'h0;
      cal_we   <= 1'b0;
      cal_dst  <= 3'h0;
      cal_out  <= 16'h0;
    end else begin
      cal_we <= 1'b0;
      cal_rd <= (state == SADC_CAL) && !cal_valid && !cal_we;
      if (state == SADC_CAL && cal_valid) begin
        cal_we   <= 1'b1; // R15
        cal_dst  <= cal_cnt[2:0];
        cal_out  <= cal_word;
        cal_cnt  <= cal_cnt + 4'h1;
        cal_addr <= cal_cnt[2:0] + 3'h1;
      end
    end
  end

  // Main sequencer across calibration, polling and acquisition.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state     <= SADC_CAL;
      mode_cont <= 1'b0;
      pt_cnt    <= 32'h0;
      done_flag <= 1'b0;
    end else begin
      case (state)
        SADC_CAL: begin
          if (cal_cnt == 4'(`SADC_CAL_WORDS)) begin
            state <= SADC_IDLE; // R15
          end
        end
        SADC_IDLE: begin
          if (wr_cyc && pready && paddr == `SADC_A_CTRL) begin
            if (pwdata[`SADC_CTL_POLL]) begin
              state     <= SADC_POLL; // R2
              done_flag <= 1'b0;
            end else if (pwdata[`SADC_CTL_SINGLE] ||
                         pwdata[`SADC_CTL_CONT]) begin
              mode_cont <= pwdata[`SADC_CTL_CONT];
              pt_cnt    <= 32'h0;
              done_flag <= 1'b0;
              state     <= SADC_ARM;
            end
          end
        end
        SADC_POLL: begin
          if (adc_done && avg_cnt == avg_n - 16'h1) begin
            state     <= SADC_IDLE; // R8
            done_flag <= 1'b1;
          end
        end
        SADC_ARM: begin
          if (wr_cyc && paddr == `SADC_A_CTRL &&
              pwdata[`SADC_CTL_STOP]) begin
            state <= SADC_IDLE;
          end else if (trig_ok) begin
            state <= SADC_RUN; // R4
          end
        end
        SADC_RUN: begin
          if (wr_cyc && paddr == `SADC_A_CTRL &&
              pwdata[`SADC_CTL_STOP]) begin
            state     <= SADC_IDLE; // R10
            done_flag <= 1'b1;
          end else if (adc_done) begin
            if (!mode_cont && pt_cnt == points - 32'h1) begin
              state     <= SADC_IDLE; // R9
              done_flag <= 1'b1;
            end
            pt_cnt <= pt_cnt + 32'h1;
          end
        end
        default: state <= SADC_IDLE;
      endcase
    end
  end

  // Conversion start: pacing timer only in acquisition, command in polling.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pace_cnt   <= 32'h0;
      adc_convst <= 1'b0;
      conv_pend  <= 1'b0;
    end else begin
      adc_convst <= 1'b0;
      if (adc_done) begin
        conv_pend <= 1'b0;
      end
      if (state == SADC_POLL) begin
        if (!conv_pend && !adc_convst) begin
          adc_convst <= 1'b1; // R3
          conv_pend  <= 1'b1;
        end
      end else if (state == SADC_RUN) begin
        if (pace_cnt == 32'h0) begin
          pace_cnt   <= (`SADC_CLK_HZ / rate) - 32'h1; // R11
          adc_convst <= !push_busy;
        end else begin
          pace_cnt <= pace_cnt - 32'h1;
        end
      end else begin
        pace_cnt <= 32'h0;
      end
    end
  end

  // One strobe captures all four channels together; averaging in polling.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avg_cnt <= 16'h0;
      for (int i = 0; i < 4; i++) begin
        acc[i]    <= 32'h0;
        result[i] <= 16'h0;
        hold[i]   <= 16'h0;
      end
    end else if (adc_done) begin
      for (int i = 0; i < 4; i++) begin
        hold[i] <= align(adc_data[16*i +: 16]); // R1
      end
      if (state == SADC_POLL) begin
        if (avg_cnt == avg_n - 16'h1) begin
          avg_cnt <= 16'h0;
          for (int i = 0; i < 4; i++) begin
            result[i] <= 16'((acc[i] + 32'(adc_data[16*i +: 16])) /
                             32'(avg_n)); // R8
            acc[i]    <= 32'h0;
          end
        end else begin
          avg_cnt <= avg_cnt + 16'h1;
          for (int i = 0; i < 4; i++) begin
            acc[i] <= acc[i] + 32'(adc_data[16*i +: 16]);
          end
        end
      end
    end
  end

  // Enabled channels go to the FIFO lowest first; a full FIFO drops the conversion start at a pacing tick.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      push_busy  <= 1'b0;
      ch_idx     <= 2'h0;
      f_in_valid <= 1'b0;
      f_in_data  <= 16'h0;
    end else begin
      if (f_in_valid && f_in_ready) begin
        f_in_valid <= 1'b0;
        if (ch_idx == 2'h3) begin
          push_busy <= 1'b0;
        end
        ch_idx <= ch_idx + 2'h1;
      end else if (push_busy && !f_in_valid) begin
        if (chen[ch_idx]) begin
          f_in_valid <= 1'b1; // R13
          f_in_data  <= hold[ch_idx]; // R19
        end else if (ch_idx == 2'h3) begin
          push_busy <= 1'b0;
          ch_idx    <= 2'h0;
        end else begin
          ch_idx <= ch_idx + 2'h1;
        end
      end
      if (adc_done && state == SADC_RUN) begin
        push_busy <= 1'b1; // R5
        ch_idx    <= 2'h0;
      end
    end
  end

  assign fifo_flush  = (state == SADC_ARM);
  assign f_out_ready = rd_cyc && pready && paddr == `SADC_A_DATA;

  sadc_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (fifo_flush),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );

  // Read mux; the data word carries the sample with its low byte first.
  always_comb begin
    case (paddr)
      `SADC_A_STATUS: next_prdata = {16'(f_level), 10'h0,
                        f_out_valid, done_flag, 1'b0, state};
      `SADC_A_RATE:   next_prdata = rate;
      `SADC_A_POINTS: next_prdata = points;
      `SADC_A_CHCFG:  next_prdata = {20'h0, chcfg};
      `SADC_A_AVG:    next_prdata = {16'h0, avg_n};
      `SADC_A_TRIG:   next_prdata = {30'h0, trig_src};
      `SADC_A_DATA:   next_prdata = {15'h0, f_out_valid,
                                     f_out_data}; // R19
      `SADC_A_SAMP01: next_prdata = {result[1], result[0]};
      `SADC_A_SAMP23: next_prdata = {result[3], result[2]};
      `SADC_A_CHEN:   next_prdata = {28'h0, chen};
      default:        next_prdata = 32'h0;
    endcase
  end

  // Read data is registered in the setup cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0;
      busy   <= 1'b1;
    end else begin
      prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h0;
      busy   <= (state != SADC_IDLE);
    end
  end
endmodule : sadc_ctrl

// ===== test/sadc_ctrl_monitor.sv
// Port checker for the acquisition controller, bound to its top module.
`timescale 1ns/1ns
module sadc_ctrl_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       adc_convst,
  input wire logic [11:0] adc_range_pol,
  input wire logic       cal_we,
  input wire logic       busy
);
  logic [3:0] cal_cnt;

  // Counts calibration writes; no conversion may start before all eight.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      cal_cnt <= 4'h0;
    else if (cal_we && cal_cnt != 4'h8)
      cal_cnt <= cal_cnt + 4'h1;
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  pready_one_a: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  pready_phase_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  pready_timely_a: assert property (psel && !penable |=> pready)
    else $error("access phase not answered at once");
  slverr_pair_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  slverr_unmap_a: assert property (
    psel && penable && pready && paddr > 8'h28 |-> pslverr)
    else $error("unmapped access not flagged");
  convst_pulse_a: assert property (adc_convst |=> !adc_convst)
    else $error("conversion start longer than one cycle");
  convst_busy_a: assert property (adc_convst |-> busy)
    else $error("conversion started while idle");
  cal_first_a: assert property (adc_convst |-> cal_cnt == 4'h8)
    else $error("conversion before calibration finished");
  range_idle_a: assert property (
    !$stable(adc_range_pol) |-> !$past(busy))
    else $error("range setting changed while busy");

  conv_c: cover property (adc_convst);
  unmap_c: cover property (pslverr);
  cal_c: cover property (cal_we);
endmodule : sadc_ctrl_monitor

bind sadc_ctrl sadc_ctrl_monitor u_mon (.clk, .sys_rst, .psel, .penable,
  .paddr, .pready, .pslverr, .adc_convst, .adc_range_pol, .cal_we, .busy);

// ===== test/sadc_conv_model.sv
// Behavioural converter and calibration memory facing the controller.
`timescale 1ns/1ns
module sadc_conv_model (
  input wire logic         clk,
  input wire logic         sys_rst,
  input wire logic         adc_convst,
  input wire logic         cal_rd,
  input wire logic         slow,
  input wire logic [2:0]   cal_addr,
  output logic             adc_done,
  output logic             cal_valid,
  output logic [63:0]      adc_data,
  output logic [15:0]      cal_word,
  output logic [15:0]      conv_count
);
  logic [3:0] conv_wait;
  logic [3:0] cal_wait;
  logic [15:0] v;

  assign v = {conv_count[14:0], 1'b0};

  // A conversion answers after 2 or 9 cycles; data toggles outside done.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_wait <= 4'h0;
      adc_done <= 1'b0;
      adc_data <= 64'h0;
      conv_count <= 16'h0;
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_convst && conv_wait == 4'h0)
        conv_wait <= slow ? 4'h9 : 4'h2;
      else if (conv_wait == 4'h1) begin
        adc_done <= 1'b1;
        adc_data <= {16'h3000 + v, 16'h2000 + v, 16'h1000 + v, v};
        conv_count <= conv_count + 16'h1;
        conv_wait <= 4'h0;
      end else if (conv_wait != 4'h0)
        conv_wait <= conv_wait - 4'h1;
    end
  end

  // Calibration words come back three cycles after a read request.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_wait <= 4'h0;
      cal_valid <= 1'b0;
      cal_word <= 16'h0;
    end else begin
      cal_valid <= 1'b0;
      cal_word <= ~cal_word;
      if (cal_rd && cal_wait == 4'h0 && !cal_valid)
        cal_wait <= 4'h3;
      else if (cal_wait == 4'h1) begin
        cal_valid <= 1'b1;
        cal_word <= {13'h0A5, cal_addr};
        cal_wait <= 4'h0;
      end else if (cal_wait != 4'h0)
        cal_wait <= cal_wait - 4'h1;
    end
  end
endmodule : sadc_conv_model

// ===== test/sadc_ctrl_bench.sv
// Self-checking bench for the acquisition controller.
`timescale 1ns/1ns
`include "sadc_defs.svh"
module sadc_ctrl_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, adc_convst, adc_done, cal_rd, cal_valid;
  logic cal_we, busy, err;
  logic ext_dig_trig = 1'b0;
  logic ana_trig_hit = 1'b0;
  logic slow = 1'b0;
  logic [63:0] adc_data;
  logic [11:0] adc_range_pol;
  logic [2:0] cal_addr, cal_dst;
  logic [15:0] cal_word, cal_out, conv_count, base;
  int n_errors = 0;
  int checked = 0;

  sadc_ctrl uut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .adc_convst, .adc_done,
    .adc_data, .adc_range_pol, .ext_dig_trig, .ana_trig_hit, .cal_rd,
    .cal_addr, .cal_valid, .cal_word, .cal_we, .cal_dst, .cal_out, .busy);
  sadc_conv_model conv (.clk, .sys_rst, .adc_convst, .cal_rd, .slow,
    .cal_addr, .adc_done, .cal_valid, .adc_data, .cal_word, .conv_count);

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One bus transfer; request held until pready is seen at an edge.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      $display("FAIL %0t bus transfer not answered", $time);
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // Bounded waits; a limit that runs out counts as a mismatch.
  task automatic wait_idle;
    int t;
    t = 0;
    repeat (3) @(posedge clk);
    while (busy !== 1'b0 && t < 3000) begin
      @(posedge clk);
      t++;
    end
    if (busy !== 1'b0) begin
      n_errors++;
      $display("FAIL %0t timed out waiting for idle", $time);
    end
  endtask : wait_idle

  task automatic wait_conv(input logic [15:0] n);
    int t;
    t = 0;
    while (conv_count - base < n && t < 3000) begin
      @(posedge clk);
      t++;
    end
    if (t >= 3000) begin
      n_errors++;
      $display("FAIL %0t timed out waiting for conversions", $time);
    end
  endtask : wait_conv

  task automatic test_done;
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // Watchdog: the tests need well under 20000 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    test_done();
  end

  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    wait_idle();
    chk({20'h0, adc_range_pol}, 32'h0);
    chk({13'h0, cal_dst, cal_out}, {13'h0, 3'h7, 13'h0A5, 3'h7});
    rdchk(`SADC_A_RATE, `SADC_RATE_RST);
    rdchk(`SADC_A_POINTS, `SADC_POINTS_RST);
    wr(`SADC_A_RATE, 32'h0);
    rdchk(`SADC_A_RATE, `SADC_RATE_RST);
    wr(`SADC_A_RATE, `SADC_MAXRATE_16 + 32'h1);
    rdchk(`SADC_A_RATE, `SADC_RATE_RST);
    wr(`SADC_A_POINTS, 32'h0);
    rdchk(`SADC_A_POINTS, `SADC_POINTS_RST);
    wr(`SADC_A_POINTS, `SADC_SINGLE_MAX);
    rdchk(`SADC_A_POINTS, `SADC_POINTS_RST);
    wr(`SADC_A_RATE, `SADC_MAXRATE_16);
    rdchk(`SADC_A_RATE, `SADC_MAXRATE_16);
    wr(`SADC_A_POINTS, 32'h3);
    rdchk(`SADC_A_POINTS, 32'h3);
    xfer(1'b0, 8'h2C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Averaged poll of four conversions; mean of 2b..2b+6 is 2b+3.
    wr(`SADC_A_CHCFG, 32'h1);
    wr(`SADC_A_AVG, 32'h4);
    base = conv_count;
    wr(`SADC_A_CTRL, 32'h1);
    wait_idle();
    chk(conv_count - base, 32'h4);
    rdchk(`SADC_A_SAMP01, {16'(16'h1003 + 2 * base),
                           16'(16'h3 + 2 * base)});
    rdchk(`SADC_A_STATUS, 32'h11);
    chk({20'h0, adc_range_pol}, 32'h1);
    repeat (300) @(posedge clk);
    chk(conv_count - base, 32'h4);
    // Single shot on channels 0 and 2, digital trigger, slow converter.
    slow <= 1'b1;
    wr(`SADC_A_CHEN, 32'h5);
    wr(`SADC_A_TRIG, 32'h1);
    base = conv_count;
    wr(`SADC_A_CTRL, 32'h2);
    repeat (600) @(posedge clk);
    chk(conv_count - base, 32'h0);
    ext_dig_trig <= 1'b1;
    wait_conv(16'h3);
    ext_dig_trig <= 1'b0;
    repeat (600) @(posedge clk);
    chk(conv_count - base, 32'h3);
    for (int n = 0; n < 3; n++) begin
      rdchk(`SADC_A_DATA, {15'h0, 1'b1, 16'(2 * (base + n))});
      rdchk(`SADC_A_DATA, {15'h0, 1'b1,
                           16'(16'h2000 + 2 * (base + n))});
    end
    xfer(1'b0, `SADC_A_DATA, 32'h0);
    chk({31'h0, rd[16]}, 32'h0);
    // Continuous run on the analog trigger, stopped by the host.
    slow <= 1'b0;
    wr(`SADC_A_TRIG, 32'h2);
    ana_trig_hit <= 1'b1;
    base = conv_count;
    wr(`SADC_A_CTRL, 32'h4);
    wait_conv(16'h4);
    wr(`SADC_A_RATE, 32'h7D0);
    wr(`SADC_A_CTRL, 32'h8);
    wait_idle();
    ana_trig_hit <= 1'b0;
    // Let a conversion started at the stop edge finish before counting.
    repeat (8) @(posedge clk);
    base = conv_count;
    repeat (600) @(posedge clk);
    chk(conv_count - base, 32'h0);
    rdchk(`SADC_A_RATE, `SADC_MAXRATE_16);
    test_done();
  end
endmodule : sadc_ctrl_bench
